/* rbc_reset_config.sv */
// Reset sequencer with strap capture and status register.
`timescale 1ns/1ps
`include "rbc_defines.svh"
module rbc_reset_config
    import rbc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reset_in_n,
    input wire logic int_reset_req,
    input wire rbc_src_t int_reset_src,
    input wire logic has_ext_bus,
    input wire logic config_source_select,
    input wire logic [1:0] boot_select,
    input wire logic osc_mode_select,
    input wire logic weak_pull_select,
    input wire logic debug_event_in,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic reset_output_n,
    output logic internal_reset_n,
    output logic pull_up_en,
    output logic pull_down_en,
    output logic debug_port_en,
    output logic debug_event_pulse,
    output logic trace_data_out0,
    output rbc_boot_t boot_mode,
    output logic osc_crystal
);
    // Sequencer state and its cycle counter.
    rbc_state_t state;
    logic [5:0] count;
    // Source of the reset in progress.
    rbc_src_t src;
    // Filter outputs.
    logic qualified;
    logic glitch;
    // Decoder outputs.
    rbc_boot_t dec_boot;
    logic dec_osc;
    // Reset status register bits, gathered from the fields below.
    logic [`RBC_ST_WIDTH-1:0] status;
    // Status fields, each kept by a single process so no bit has two drivers.
    logic st_pull;
    logic [1:0] st_boot;
    logic st_osc;
    logic st_debug;
    logic st_glitch;
    // Control register: bit 0 requests a software internal reset.
    logic sw_reset;
    // Delayed debug input for edge detection after reset.
    logic debug_prev;
    // Oscillator settle counter after power-on.
    logic [7:0] osc_count;
    // Any reset request this cycle.
    logic any_req;

    rbc_filter u_filter (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .reset_in_n(reset_in_n),
        .qualified(qualified),
        .glitch(glitch)
    );

    rbc_boot_decode u_decode (
        .has_ext_bus(has_ext_bus),
        .config_source_select(config_source_select),
        .boot_select(boot_select),
        .osc_mode_select(osc_mode_select),
        .boot_mode(dec_boot),
        .osc_crystal(dec_osc)
    );

    // Requests from the pin, other blocks, or software all start a reset.
    always_comb begin
        any_req = qualified || int_reset_req || sw_reset;
    end

    // Place the status fields at their register positions.
    always_comb begin
        status = 6'h00;
        status[`RBC_ST_PULL] = st_pull;
        status[`RBC_ST_BOOT_HI:`RBC_ST_BOOT_LO] = st_boot;
        status[`RBC_ST_OSC] = st_osc;
        status[`RBC_ST_DEBUG] = st_debug;
        status[`RBC_ST_GLITCH] = st_glitch;
    end

    // Sequencer: delay, then hold the output low; a new request restarts it.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= RBC_DELAY;
            count <= 6'h0;
        end else if (any_req) begin
            state <= RBC_DELAY;
            count <= 6'h0;
        end else begin
            unique case (state)
                RBC_RUN: begin
                    count <= 6'h0;
                end
                RBC_DELAY: begin
                    if (count[3:0] == `RBC_OUT_DELAY - 4'h1) begin
                        state <= RBC_HOLD;
                        count <= 6'h0;
                    end else begin
                        count <= count + 6'h1;
                    end
                end
                RBC_HOLD: begin
                    if (count == `RBC_HOLD_CYCLES - 6'h1) begin
                        state <= RBC_RUN;
                        count <= 6'h0;
                    end else begin
                        count <= count + 6'h1;
                    end
                end
            endcase
        end
    end

    // Remember the source; pin reset counts as external. Power-on counts as external too.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            src <= RBC_SRC_EXT;
        end else if (qualified) begin
            src <= RBC_SRC_EXT;
        end else if (int_reset_req) begin
            src <= int_reset_src;
        end else if (sw_reset) begin
            src <= RBC_SRC_INT;
        end
    end

    // Reset outputs follow the state; every source drives the pin low.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reset_output_n <= 1'b1;
            internal_reset_n <= 1'b0;
        end else if (any_req) begin
            // A request holds the pin where it is, so a restart never lets it blink high.
            reset_output_n <= reset_output_n;
            internal_reset_n <= 1'b0;
        end else begin
            // Low through the hold; a restarted delay keeps a pin that is already low.
            reset_output_n <= !((state == RBC_HOLD && count != `RBC_HOLD_CYCLES - 6'h1) ||
                                (state == RBC_DELAY && !reset_output_n));
            internal_reset_n <= (state == RBC_RUN);
        end
    end

    // Pull strap captured four cycles before release, skipped for debug/sw-ext.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_pull <= 1'b0;
        end else if (state == RBC_HOLD && count == `RBC_PULL_SAMPLE - 6'h1 && !any_req &&
                     src != RBC_SRC_DEBUG && src != RBC_SRC_SWEXT) begin
            st_pull <= weak_pull_select;
        end
    end

    // Boot and oscillator straps sampled while the output is low.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_boot <= 2'h0;
            st_osc <= 1'b0;
            boot_mode <= RBC_BOOT_FLASH;
            osc_crystal <= 1'b0;
        end else if (!reset_output_n) begin
            st_boot <= dec_boot;
            st_osc <= dec_osc;
            boot_mode <= dec_boot;
            osc_crystal <= dec_osc;
        end
    end

    // Debug enable read at release; afterwards the input makes event pulses.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_debug <= 1'b0;
            debug_port_en <= 1'b0;
            debug_prev <= 1'b1;
            debug_event_pulse <= 1'b0;
        end else begin
            debug_prev <= debug_event_in;
            debug_event_pulse <= 1'b0;
            if (state == RBC_HOLD && count == `RBC_HOLD_CYCLES - 6'h1 && !any_req) begin
                st_debug <= debug_event_in;
                debug_port_en <= debug_event_in;
            end else if (internal_reset_n) begin
                debug_event_pulse <= debug_port_en && debug_prev && !debug_event_in;
            end
        end
    end

    // Glitch flag is sticky; a new glitch wins over a software clear.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_glitch <= 1'b0;
        end else if (glitch) begin
            st_glitch <= 1'b1;
        end else if (reg_write && reg_addr == `RBC_ADDR_STATUS && reg_wdata[`RBC_ST_GLITCH]) begin
            st_glitch <= 1'b0;
        end
    end

    // Weak pulls on channel pins after reset, direction from the strap.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pull_up_en <= 1'b0;
            pull_down_en <= 1'b0;
        end else begin
            pull_up_en <= internal_reset_n && status[`RBC_ST_PULL];
            pull_down_en <= internal_reset_n && !status[`RBC_ST_PULL];
        end
    end

    // Trace bit high after power-on until the oscillator settle count expires.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            osc_count <= 8'h0;
            trace_data_out0 <= 1'b1;
        end else if (osc_count != `RBC_OSC_SETTLE) begin
            osc_count <= osc_count + 8'h1;
            trace_data_out0 <= 1'b1;
        end else begin
            trace_data_out0 <= 1'b0;
        end
    end

    // Software reset request is a self-clearing one-cycle strobe.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sw_reset <= 1'b0;
        end else begin
            sw_reset <= reg_write && reg_addr == `RBC_ADDR_CTRL && reg_wdata[0];
        end
    end

    // Read data in the cycle after the strobe only; unmapped reads give zero.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else if (reg_read && reg_addr == `RBC_ADDR_STATUS) begin
            reg_rdata <= {26'h0, status};
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // Output falls only out of the first hold cycle, never straight off a request.
    a_out_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(reset_output_n) |-> $past(state == RBC_HOLD && count == 6'h0 && !any_req))
        else $error("reset output fell without delay");
    // A request leaves the reset output where it was for one cycle.
    a_req_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        any_req |=> $stable(reset_output_n))
        else $error("reset output moved on a request");
    // Qualified pin reset leads to output low within a few cycles.
    a_qual_out: assert property (@(posedge clk_sys) disable iff (!rst_b)
        qualified |-> ##[1:4] !reset_output_n)
        else $error("qualified reset did not drive output");
    // New request restarts the sequence.
    a_restart: assert property (@(posedge clk_sys) disable iff (!rst_b)
        any_req |=> state == RBC_DELAY && count == 6'h0)
        else $error("reset not restarted");
    // A restart in mid-reset keeps the reset output low.
    a_restart_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
        any_req && !reset_output_n |=> !reset_output_n)
        else $error("reset output released by a restart");
    // Pull enables are exclusive.
    a_pull_excl: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(pull_up_en && pull_down_en))
        else $error("both pulls enabled");
    // Pull direction follows status.
    a_pull_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pull_up_en |-> $past(status[`RBC_ST_PULL]))
        else $error("pull direction wrong");
    // Boot mode stable while running.
    a_boot_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reset_output_n && $past(reset_output_n) |-> $stable(boot_mode))
        else $error("boot mode changed outside reset");
    // No internal release while output low.
    a_rel_order: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !reset_output_n |-> !internal_reset_n)
        else $error("internal released while output low");
    // Glitch sets the status flag in the next cycle.
    a_glitch_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
        glitch |=> status[`RBC_ST_GLITCH])
        else $error("glitch flag not set");
    c_restart: cover property (@(posedge clk_sys) disable iff (!rst_b) any_req && !reset_output_n);
    c_pin_reset: cover property (@(posedge clk_sys) disable iff (!rst_b) qualified);
    c_glitch: cover property (@(posedge clk_sys) disable iff (!rst_b) glitch);
    c_release: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(internal_reset_n));
endmodule : rbc_reset_config

/* rbc_defines.svh */
// Timing counts, field positions and register offsets for the reset and boot configuration block.
`ifndef RBC_DEFINES_SVH
`define RBC_DEFINES_SVH
// Cycles the reset input must stay low before internal reset asserts.
`define RBC_QUAL_CYCLES 4'hA
// Shortest low pulse, in cycles, that the glitch detector reports (more than two).
`define RBC_GLITCH_CYCLES 4'h3
// Cycles in the delay state; the reset output goes low three cycles after internal reset starts.
`define RBC_OUT_DELAY 4'h2
// Cycles in the hold state; the reset output is held low for one fewer in total.
`define RBC_HOLD_CYCLES 6'h20
// Cycle count at which the pull strap is sampled, four before release.
`define RBC_PULL_SAMPLE 6'h1C
// Cycles to wait for the crystal oscillator to settle after power-on.
`define RBC_OSC_SETTLE 8'h40
// Status register field positions.
`define RBC_ST_PULL 0
`define RBC_ST_BOOT_LO 1
`define RBC_ST_BOOT_HI 2
`define RBC_ST_OSC 3
`define RBC_ST_DEBUG 4
`define RBC_ST_GLITCH 5
`define RBC_ST_WIDTH 6
// Register offsets on the plain register port.
`define RBC_ADDR_STATUS 4'h0
`define RBC_ADDR_CTRL 4'h4
`endif

/* rbc_pkg.sv */
// Types shared by the reset and boot configuration block.
package rbc_pkg;
    // Decoded boot source.
    typedef enum logic [1:0] {
        RBC_BOOT_FLASH = 2'h0,
        RBC_BOOT_SERIAL = 2'h1,
        RBC_BOOT_EXTMEM = 2'h2,
        RBC_BOOT_RSVD = 2'h3
    } rbc_boot_t;
    // Source of the reset being served.
    typedef enum logic [1:0] {
        RBC_SRC_EXT = 2'h0,
        RBC_SRC_INT = 2'h1,
        RBC_SRC_DEBUG = 2'h2,
        RBC_SRC_SWEXT = 2'h3
    } rbc_src_t;
    // Sequencer states.
    typedef enum logic [1:0] {
        RBC_RUN,
        RBC_DELAY,
        RBC_HOLD
    } rbc_state_t;
endpackage : rbc_pkg

/* rbc_filter.sv */
// Reset input qualifier and glitch detector.
`timescale 1ns/1ps
`include "rbc_defines.svh"
module rbc_filter
    import rbc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reset_in_n,
    output logic qualified,
    output logic glitch
);
    // Run length of the current low level, saturating.
    logic [3:0] low_count;

    // Count consecutive low cycles; a high cycle restarts the count.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            low_count <= 4'h0;
        end else if (reset_in_n) begin
            low_count <= 4'h0;
        end else if (low_count != 4'hF) begin
            low_count <= low_count + 4'h1;
        end
    end

    // One-cycle pulse once the input has been low for ten cycles.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            qualified <= 1'b0;
        end else begin
            qualified <= !reset_in_n && (low_count == `RBC_QUAL_CYCLES - 4'h1);
        end
    end

    // Pulse when a low pulse longer than two cycles ends before qualifying.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            glitch <= 1'b0;
        end else begin
            glitch <= reset_in_n && low_count >= `RBC_GLITCH_CYCLES && low_count < `RBC_QUAL_CYCLES;
        end
    end
endmodule : rbc_filter

/* rbc_boot_decode.sv */
// Combinational decode of boot and oscillator straps.
`timescale 1ns/1ps
module rbc_boot_decode
    import rbc_pkg::*;
(
    input wire logic has_ext_bus,
    input wire logic config_source_select,
    input wire logic [1:0] boot_select,
    input wire logic osc_mode_select,
    output rbc_boot_t boot_mode,
    output logic osc_crystal
);
    // Effective straps after package masking.
    logic cfg_src;
    logic [1:0] boot_eff;

    // Without the external bus, the config source and boot bit 1 read as zero.
    always_comb begin
        cfg_src = has_ext_bus ? config_source_select : 1'b0;
        boot_eff = has_ext_bus ? boot_select : {1'b0, boot_select[0]};
    end

    // Default config means flash with crystal; else straps decide.
    always_comb begin
        if (cfg_src) begin
            boot_mode = RBC_BOOT_FLASH;
            osc_crystal = 1'b1;
        end else begin
            boot_mode = rbc_boot_t'(boot_eff);
            osc_crystal = osc_mode_select;
        end
    end
endmodule : rbc_boot_decode

/* rbc_board_model.sv */
// Board-side model that drives the reset pin and the pull and boot straps.
`timescale 1ns/1ps
module rbc_board_model (
    input wire logic clk_sys,
    input wire logic reset_output_n,
    input wire logic go,
    input wire logic [7:0] len,
    input wire logic pull_val,
    input wire logic [1:0] boot_val,
    output logic reset_in_n,
    output logic weak_pull_select,
    output logic [1:0] boot_select
);
    // Sampled edges of low drive still to come.
    logic [7:0] left = 8'h00;
    // A request loads the count; the pin stays low for exactly len edges.
    always @(posedge clk_sys) begin
        if (go) begin
            left <= len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // The pin is low only while the count runs.
    assign reset_in_n = (left == 8'h00);
    // Straps hold the wanted value only while the reset output is low.
    // Outside it they show the inverse, so a capture taken late is caught.
    assign weak_pull_select = reset_output_n ? !pull_val : pull_val;
    assign boot_select = reset_output_n ? ~boot_val : boot_val;
endmodule : rbc_board_model

/* reset_and_boot_config_tb.sv */
// Self-checking bench for the reset sequencer and strap capture.
`timescale 1ns/1ps
module reset_and_boot_config_tb;
    import rbc_pkg::*;
    // Inputs start at known levels at time zero.
    logic clk_sys, rst_b = 1'b0, go = 1'b0, pull_val = 1'b0, int_reset_req = 1'b0;
    logic has_ext_bus = 1'b1, config_source_select = 1'b0, osc_mode_select = 1'b0;
    logic debug_event_in = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0] len = 8'h00;
    logic [1:0] boot_val = 2'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    rbc_src_t int_reset_src = RBC_SRC_EXT;
    // Outputs of the design and the board model.
    logic reset_in_n, weak_pull_select, reset_output_n, internal_reset_n, pull_up_en, pull_down_en;
    logic debug_port_en, debug_event_pulse, trace_data_out0, osc_crystal;
    logic [1:0] boot_select;
    logic [31:0] reg_rdata;
    rbc_boot_t boot_mode;
    int err_count = 0, check_count = 0;

    rbc_reset_config u_rbc_reset_config (.clk_sys, .rst_b, .reset_in_n, .int_reset_req, .int_reset_src,
        .has_ext_bus, .config_source_select, .boot_select, .osc_mode_select, .weak_pull_select,
        .debug_event_in, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reset_output_n,
        .internal_reset_n, .pull_up_en, .pull_down_en, .debug_port_en, .debug_event_pulse,
        .trace_data_out0, .boot_mode, .osc_crystal);
    rbc_board_model u_rbc_board_model (.clk_sys, .reset_output_n, .go, .len, .pull_val, .boot_val,
        .reset_in_n, .weak_pull_select, .boot_select);

    // Free-running 200 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // One compare for every result; unknowns never match.
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // Waits n edges and lets their updates settle.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    // Single-cycle register write.
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : reg_wr

    // Single-cycle register read; data stand only in the next cycle.
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_rd

    // Asks the board model for a low pulse of n cycles.
    task automatic ext(input logic [7:0] n);
        @(posedge clk_sys);
        len <= n;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask : ext

    // Bounded wait for the reset output to reach a level.
    task automatic wait_lvl(input logic v);
        int i;
        i = 0;
        while (reset_output_n !== v && i < 100) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        check("rst_out_level", 1, i < 100);
    endtask : wait_lvl

    task automatic wait_rel();
        wait_lvl(1'b0);
        wait_lvl(1'b1);
    endtask : wait_rel

    // Power-on run: trace bit stays high until the oscillator has settled.
    task automatic t_por();
        wait_rel();
        check("trace_early", 1, trace_data_out0);
        tick(80);
        check("trace_late", 0, trace_data_out0);
    endtask : t_por

    // Short pulses must not reset; glitches are flagged; ten cycles reset.
    task automatic t_qual();
        int n, ni, seen;
        logic [31:0] d;
        ext(8'h09);
        seen = 0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            if (reset_output_n !== 1'b1) seen = 1;
        end
        check("nine_low", 0, seen);
        reg_rd(4'h0, d);
        check("glitch_nine", 1, d[5]);
        reg_wr(4'h0, 32'h20);
        ext(8'h02);
        tick(15);
        reg_rd(4'h0, d);
        check("glitch_two", 0, d[5]);
        ext(8'h03);
        tick(15);
        reg_rd(4'h0, d);
        check("glitch_three", 1, d[5]);
        ext(8'h0A);
        n = 0;
        ni = 0;
        while (reset_output_n !== 1'b0 && n < 40) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (internal_reset_n === 1'b0 && ni == 0) ni = n;
        end
        check("qual_time", 1, n >= 11 && n <= 16);
        check("out_delay", 1, ni != 0 && ni < n);
        wait_lvl(1'b1);
    endtask : t_qual

    // A new request in mid-hold stretches the reset beyond its plain length.
    task automatic t_restart();
        int seen;
        ext(8'h0A);
        wait_lvl(1'b0);
        tick(15);
        ext(8'h0A);
        seen = 0;
        repeat (25) begin
            @(posedge clk_sys);
            #1;
            if (reset_output_n !== 1'b0) seen = 1;
        end
        check("restart_low", 0, seen);
        wait_lvl(1'b1);
    endtask : t_restart

    // Each strap set gives its boot mode, clock mode and pull direction.
    task automatic t_boot();
        logic [7:0] tab [6];
        logic [31:0] d;
        // Fields: package bus, source select, boot straps, osc strap, boot mode, crystal.
        tab = '{8'h80, 8'h9B, 8'hA4, 8'hBF, 8'hE1, 8'h72};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            has_ext_bus <= tab[i][7];
            config_source_select <= tab[i][6];
            boot_val <= tab[i][5:4];
            osc_mode_select <= tab[i][3];
            pull_val <= i[0];
            ext(8'h0A);
            wait_rel();
            tick(3);
            check("boot_mode", tab[i][2:1], boot_mode);
            check("osc_crystal", tab[i][0], osc_crystal);
            check("pull_up", i[0], pull_up_en);
            check("pull_down", !i[0], pull_down_en);
            reg_rd(4'h0, d);
            check("st_pull", i[0], d[0]);
            check("st_boot", {tab[i][0], tab[i][2:1]}, d[3:1]);
        end
    endtask : t_boot

    // Internal sources reset too; debug and software-external keep the stored strap.
    task automatic t_int();
        rbc_src_t s [3];
        logic [31:0] d;
        s = '{RBC_SRC_DEBUG, RBC_SRC_SWEXT, RBC_SRC_INT};
        pull_val <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            int_reset_src <= s[k];
            int_reset_req <= 1'b1;
            @(posedge clk_sys);
            int_reset_req <= 1'b0;
            wait_rel();
            reg_rd(4'h0, d);
            check("st_pull_src", k < 2, d[0]);
        end
        reg_wr(4'h4, 32'h1);
        wait_rel();
        reg_rd(4'h8, d);
        check("unmapped", 0, d);
    endtask : t_int

    // One debug run: level held through release, then a falling event.
    task automatic dbg(input logic v, output logic en, output logic seen);
        logic [31:0] d;
        @(posedge clk_sys);
        debug_event_in <= v;
        ext(8'h0A);
        wait_rel();
        tick(2);
        en = debug_port_en;
        reg_rd(4'h0, d);
        check("st_debug", v, d[4]);
        @(posedge clk_sys);
        debug_event_in <= 1'b1;
        tick(2);
        @(posedge clk_sys);
        debug_event_in <= 1'b0;
        seen = 0;
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            if (debug_event_pulse === 1'b1) seen = 1;
        end
    endtask : dbg

    // The two release levels give opposite enables; events pass only when enabled.
    task automatic t_debug();
        logic e1, s1, e0, s0;
        dbg(1'b1, e1, s1);
        dbg(1'b0, e0, s0);
        check("dbg_en", 1, e1 ^ e0);
        check("dbg_evt_a", e1, s1);
        check("dbg_evt_b", e0, s0);
    endtask : t_debug

    // Single place where the run ends.
    task automatic test_done();
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_por();
        t_qual();
        t_restart();
        t_boot();
        t_int();
        t_debug();
        test_done();
    end

    // The tests need under 2000 cycles; a hang is cut off well beyond that.
    initial begin
        #100000;
        err_count++;
        test_done();
    end
endmodule : reset_and_boot_config_tb
